// ===== src/cepir_hs_decide.sv
// Handshake choice for a host IN request to endpoint zero.
`timescale 1ns/1ps
module cepir_hs_decide (
    // Request and state
    input  wire logic                 in_req,
    input  wire logic                 stall,
    input  wire logic                 nak,
    // Decision
    output cepir_pkg::cepir_hs_t      hs
);
    import cepir_pkg::*;

    always_comb begin
        if (!in_req) begin
            hs = CEPIR_HS_NONE;
        end else if (stall) begin
            hs = CEPIR_HS_STALL;
        end else if (nak) begin
            hs = CEPIR_HS_NAK;
        end else begin
            hs = CEPIR_HS_DATA;
        end
    end

endmodule

// ===== src/cepir_pkg.sv
// Package for the endpoint-zero input register block: offsets, fields, resets and types.
package cepir_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [15:0] CEPIR_OFS_IN_CONFIG     = 16'hF000;
    localparam logic [15:0] CEPIR_OFS_IN_BYTE_COUNT = 16'hF001;

    // ------------------------------------------------------------------
    // Field positions of the configuration and byte-count registers
    // ------------------------------------------------------------------
    localparam int CEPIR_CFG_SIZE_LO   = 0;
    localparam int CEPIR_CFG_XFER_IE   = 2;
    localparam int CEPIR_CFG_STALL     = 3;
    localparam int CEPIR_CFG_TOGGLE    = 5;
    localparam int CEPIR_CFG_NAK_IE    = 6;
    localparam int CEPIR_CFG_BUF_MGR   = 7;
    localparam int CEPIR_CNT_NAK       = 7;

    // ------------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------------
    localparam logic [7:0] CEPIR_CFG_RESET   = 8'h00;
    localparam logic [7:0] CEPIR_CNT_RESET   = 8'h80;
    localparam logic [6:0] CEPIR_MAX_COUNT   = 7'h40;

    // ------------------------------------------------------------------
    // Fixed buffer placement
    // ------------------------------------------------------------------
    localparam logic [15:0] CEPIR_OUT_BUF_START = 16'hE000;
    localparam logic [15:0] CEPIR_IN_BUF_BASE   = 16'hE000;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CEPIR_HS_NONE,
        CEPIR_HS_DATA,
        CEPIR_HS_NAK,
        CEPIR_HS_STALL
    } cepir_hs_t;

    // Register read and write strobes, address and write data from the microcontroller external data space.
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } cepir_xbus_t;

    // Events from the protocol engine.
    typedef struct packed {
        logic in_req;
        logic in_acked;
        logic setup_rx;
    } cepir_usb_ev_t;

    // Buffer size in bytes for a size code.
    function automatic logic [6:0] cepir_size_bytes(input logic [1:0] code);
        return 7'h08 << code;
    endfunction

endpackage

// ===== src/cepir_top.sv
// Endpoint-zero input configuration and byte-count registers with IN handshake control.
//
// Contract
// - The two-bit size code selects an 8, 16, 32 or 64 byte endpoint-zero buffer.
// - Buffer starts are fixed: output at E000, input at E008/E010/E020/E040 by size code.
// - With the transfer interrupt enable set, each completed transaction raises an interrupt.
// - With the NAK interrupt enable set, each NAK returned to the host raises an interrupt.
// - The buffer manager may use the endpoint only while its enable bit is set.
// - A written count above MAX_COUNT, 0x40 by default, is stored as MAX_COUNT.
// - With the IN NAK bit and the stall bit clear, the buffered packet is sent on a host IN request.
// - With the IN NAK bit set, its reset state, host IN requests are answered with NAK unless the stall bit is set.
`timescale 1ns/1ps
module cepir_top #(
    // Largest byte count that the input buffer can carry.
    parameter logic [6:0] MAX_COUNT = cepir_pkg::CEPIR_MAX_COUNT
) (
    // Clock and reset
    input  wire logic                    clock,
    input  wire logic                    nrst,
    // Microcontroller external data space
    input  cepir_pkg::cepir_xbus_t       xbus,
    output logic [7:0]                   rdata,
    output logic                         rsel,
    // Protocol engine
    input  cepir_pkg::cepir_usb_ev_t     usb_ev,
    output cepir_pkg::cepir_hs_t         in_hs,
    output logic [6:0]                   tx_count,
    output logic                         data_toggle_bit,
    // Buffer manager and interrupts
    output logic                         buf_mgr_enable,
    output logic [15:0]                  in_buf_start,
    output logic [15:0]                  out_buf_start,
    output logic [6:0]                   buffer_bytes,
    output logic                         irq
);
    import cepir_pkg::*;

    logic [1:0] buffer_size_code;
    logic       xfer_done_irq_en;
    logic       stall_reg;
    logic       nak_irq_en;
    logic       in_nak_reg;
    logic [6:0] count_reg;
    logic       cfg_sel;
    logic       cnt_sel;
    logic [6:0] count_next;
    logic [7:0] cfg_view;
    logic [7:0] cnt_view;
    logic       irq_next;
    cepir_hs_t  hs;

    // ------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------
    // The largest size code gives a 64 byte buffer, so a higher limit
    // would let a packet run past the end of the input buffer.
    if (MAX_COUNT == 7'h00 || MAX_COUNT > CEPIR_MAX_COUNT) begin : g_bad_max_count
        $error("MAX_COUNT must lie between 1 and 64");
    end

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // Full 16-bit compare: the pair sits among other registers of the
    // external data space, and a partial decode would alias onto them.
    assign cfg_sel = xbus.addr == CEPIR_OFS_IN_CONFIG;
    assign cnt_sel = xbus.addr == CEPIR_OFS_IN_BYTE_COUNT;

    // ------------------------------------------------------------------
    // Handshake decision
    // ------------------------------------------------------------------
    // The answer is combinational so the engine has it in the token's cycle.
    cepir_hs_decide u_cepir_hs_decide (
        .in_req (usb_ev.in_req),
        .stall  (stall_reg),
        .nak    (in_nak_reg),
        .hs     (hs)
    );
    assign in_hs = hs;

    // ------------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------------
    // Bit 5 of a write is dropped: the toggle belongs to the hardware, and
    // bit 4 is reserved.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            buffer_size_code <= CEPIR_CFG_RESET[1:0];
            xfer_done_irq_en <= 1'b0;
            nak_irq_en       <= 1'b0;
            buf_mgr_enable   <= 1'b0;
        end else if (xbus.wr && cfg_sel) begin
            buffer_size_code <= xbus.wdata[CEPIR_CFG_SIZE_LO +: 2];
            xfer_done_irq_en <= xbus.wdata[CEPIR_CFG_XFER_IE];
            nak_irq_en       <= xbus.wdata[CEPIR_CFG_NAK_IE];
            buf_mgr_enable   <= xbus.wdata[CEPIR_CFG_BUF_MGR];
        end
    end

    // Setup clears the stall even if firmware writes it in the same cycle,
    // since the setup ends the stalled control transfer.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            stall_reg <= 1'b0;
        end else if (usb_ev.setup_rx) begin
            stall_reg <= 1'b0;
        end else if (xbus.wr && cfg_sel) begin
            stall_reg <= xbus.wdata[CEPIR_CFG_STALL];
        end
    end

    // Setup wins over an acknowledge in the same cycle, since the setup
    // restarts the control transfer with the first data phase.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            data_toggle_bit <= 1'b0;
        end else if (usb_ev.setup_rx) begin
            data_toggle_bit <= 1'b0;
        end else if (usb_ev.in_acked) begin
            data_toggle_bit <= ~data_toggle_bit;
        end
    end

    // ------------------------------------------------------------------
    // Byte-count register
    // ------------------------------------------------------------------
    // Counts above the limit are corrected rather than refused, so the
    // stored count always fits the largest buffer.
    always_comb begin
        count_next = xbus.wdata[6:0];
        if (xbus.wdata[6:0] > MAX_COUNT) begin
            count_next = MAX_COUNT;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            count_reg <= CEPIR_CNT_RESET[6:0];
        end else if (xbus.wr && cnt_sel) begin
            count_reg <= count_next;
        end
    end

    // The acknowledge sets NAK over a simultaneous firmware clear, so a
    // stale buffer is never sent twice.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            in_nak_reg <= CEPIR_CNT_RESET[CEPIR_CNT_NAK];
        end else if (usb_ev.in_acked) begin
            in_nak_reg <= 1'b1;
        end else if (xbus.wr && cnt_sel) begin
            in_nak_reg <= xbus.wdata[CEPIR_CNT_NAK];
        end
    end

    assign tx_count = count_reg;

    // ------------------------------------------------------------------
    // Buffer placement and interrupt
    // ------------------------------------------------------------------
    assign buffer_bytes  = cepir_size_bytes(buffer_size_code);
    assign out_buf_start = CEPIR_OUT_BUF_START;
    // The input buffer sits directly above the output buffer, so its start
    // lies one buffer size past the shared base.
    assign in_buf_start  = CEPIR_IN_BUF_BASE | {9'h000, buffer_bytes};

    // A completed transaction is an acknowledged IN packet or a setup; the
    // NAK cause is kept apart so either enable works on its own.
    always_comb begin
        irq_next = 1'b0;
        if (xfer_done_irq_en && (usb_ev.in_acked || usb_ev.setup_rx)) begin
            irq_next = 1'b1;
        end
        if (nak_irq_en && hs == CEPIR_HS_NAK) begin
            irq_next = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_next;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Reserved bit 4 reads zero, and the toggle shows the hardware copy
    // whatever firmware last wrote to bit 5.
    always_comb begin
        cfg_view                         = 8'h00;
        cfg_view[CEPIR_CFG_SIZE_LO +: 2] = buffer_size_code;
        cfg_view[CEPIR_CFG_XFER_IE]      = xfer_done_irq_en;
        cfg_view[CEPIR_CFG_STALL]        = stall_reg;
        cfg_view[CEPIR_CFG_TOGGLE]       = data_toggle_bit;
        cfg_view[CEPIR_CFG_NAK_IE]       = nak_irq_en;
        cfg_view[CEPIR_CFG_BUF_MGR]      = buf_mgr_enable;
    end

    always_comb begin
        cnt_view                = 8'h00;
        cnt_view[6:0]           = count_reg;
        cnt_view[CEPIR_CNT_NAK] = in_nak_reg;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdata <= 8'h00;
            rsel  <= 1'b0;
        end else begin
            rsel <= xbus.rd && (cfg_sel || cnt_sel);
            if (xbus.rd && cfg_sel) begin
                rdata <= cfg_view;
            end else if (xbus.rd && cnt_sel) begin
                rdata <= cnt_view;
            end else begin
                rdata <= 8'h00;
            end
        end
    end

endmodule

// ===== verif/cepir_host_model.sv
// Host model issuing IN and SETUP events to endpoint zero.
`timescale 1ns/1ps
module cepir_host_model (
    // Clock and commands
    input wire logic          clock,
    input wire logic          do_in,
    input wire logic          do_setup,
    // Device side
    input cepir_pkg::cepir_hs_t in_hs,
    output cepir_pkg::cepir_usb_ev_t usb_ev
);
    import cepir_pkg::*;
    logic got_data = 1'b0;
    logic ack_q = 1'b0;
    // The host acknowledges only a data packet it was really sent.
    always @(posedge clock) got_data <= do_in && in_hs == CEPIR_HS_DATA;
    always @(negedge clock) ack_q <= got_data;
    // Setup comes only from the host, never from firmware.
    assign usb_ev = '{in_req: do_in, in_acked: ack_q, setup_rx: do_setup};
endmodule

// ===== verif/cepir_properties.sv
// Port checker for the endpoint-zero input register block.
`timescale 1ns/1ps
module cepir_properties (
    // Clock and reset
    input wire logic              clock,
    input wire logic              nrst,
    // Register side
    input cepir_pkg::cepir_xbus_t xbus,
    input wire logic [7:0]        rdata,
    input wire logic              rsel,
    // Endpoint side
    input cepir_pkg::cepir_usb_ev_t usb_ev,
    input cepir_pkg::cepir_hs_t   in_hs,
    input wire logic [6:0]        tx_count,
    input wire logic              data_toggle_bit,
    input wire logic              buf_mgr_enable,
    input wire logic [15:0]       in_buf_start,
    input wire logic [15:0]       out_buf_start,
    input wire logic [6:0]        buffer_bytes,
    input wire logic              irq
);
    import cepir_pkg::*;
    wire cnt_wr = xbus.wr && xbus.addr == CEPIR_OFS_IN_BYTE_COUNT;
    wire hit = xbus.addr == CEPIR_OFS_IN_CONFIG || xbus.addr == CEPIR_OFS_IN_BYTE_COUNT;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // -------
    // Rules
    // -------
    sequence s_big; cnt_wr && xbus.wdata[6:0] > CEPIR_MAX_COUNT; endsequence
    sequence s_ack; usb_ev.in_acked && !usb_ev.setup_rx; endsequence
    property p_clamp; s_big |=> tx_count == CEPIR_MAX_COUNT; endproperty
    a_clamp: assert property (p_clamp) else $error("clamp");
    property p_map; in_buf_start == 16'hE000 + {9'h000, buffer_bytes}
        && out_buf_start == 16'hE000; endproperty
    a_map: assert property (p_map) else $error("map");
    property p_stall; usb_ev.setup_rx |=> in_hs != CEPIR_HS_STALL; endproperty
    a_stall: assert property (p_stall) else $error("stall");
    property p_reload; usb_ev.in_acked |=> in_hs != CEPIR_HS_DATA; endproperty
    a_reload: assert property (p_reload) else $error("reload");
    property p_tog; s_ack |=> data_toggle_bit != $past(data_toggle_bit); endproperty
    a_tog: assert property (p_tog) else $error("toggle");
    property p_togclr; usb_ev.setup_rx |=> !data_toggle_bit; endproperty
    a_togclr: assert property (p_togclr) else $error("toggle clr");
    property p_irq; !usb_ev.in_acked && !usb_ev.setup_rx && in_hs != CEPIR_HS_NAK
        |=> !irq; endproperty
    a_irq: assert property (p_irq) else $error("irq");
    property p_unmap; xbus.rd && !hit |=> !rsel && rdata == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped");
endmodule
bind cepir_top cepir_properties u_cepir_properties (.clock(clock), .nrst(nrst),
    .xbus(xbus), .rdata(rdata), .rsel(rsel), .usb_ev(usb_ev), .in_hs(in_hs),
    .tx_count(tx_count), .data_toggle_bit(data_toggle_bit),
    .buf_mgr_enable(buf_mgr_enable), .in_buf_start(in_buf_start),
    .out_buf_start(out_buf_start), .buffer_bytes(buffer_bytes), .irq(irq));

// ===== verif/control_endpoint_in_regs_bench.sv
// Self-checking bench for the endpoint-zero input register block.
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin failures++; \
    $display("Error t=%0t got %h exp %h", $time, a, e); end end
module control_endpoint_in_regs_bench;
    import cepir_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic do_in = 1'b0;
    logic do_setup = 1'b0;
    cepir_xbus_t xbus = '0;
    cepir_usb_ev_t usb_ev;
    cepir_hs_t in_hs;
    logic [7:0] rdata;
    logic [6:0] tx_count, buffer_bytes;
    logic [15:0] in_buf_start, out_buf_start;
    logic rsel, data_toggle_bit, buf_mgr_enable, irq;
    int failures = 0;
    int total_checks = 0;
    cepir_top u_cepir_top (.clock(clock), .nrst(nrst), .xbus(xbus), .rdata(rdata),
        .rsel(rsel), .usb_ev(usb_ev), .in_hs(in_hs), .tx_count(tx_count),
        .data_toggle_bit(data_toggle_bit), .buf_mgr_enable(buf_mgr_enable),
        .in_buf_start(in_buf_start), .out_buf_start(out_buf_start),
        .buffer_bytes(buffer_bytes), .irq(irq));
    cepir_host_model u_cepir_host_model (.clock(clock), .do_in(do_in),
        .do_setup(do_setup), .in_hs(in_hs), .usb_ev(usb_ev));
    initial forever #20 clock = ~clock;
    // -------
    // Tasks
    // -------
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clock);
        xbus = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clock);
        xbus.wr = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic s);
        @(negedge clock);
        xbus = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clock);
        xbus.rd = 1'b0;
        `CHK(rdata, e)
        `CHK(rsel, s)
    endtask
    // The interrupt of an acked packet lands one cycle later than a NAK one.
    task automatic in_tx(input cepir_hs_t h, input logic q);
        @(negedge clock);
        do_in = 1'b1;
        #1;
        `CHK(in_hs, h)
        @(negedge clock);
        do_in = 1'b0;
        if (h == CEPIR_HS_DATA) @(negedge clock);
        `CHK(irq, q)
    endtask
    task automatic complete_run;
        $display("Checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #1000000;
        failures++;
        complete_run();
    end
    // -------
    // Tests
    // -------
    initial begin
        repeat (5) @(negedge clock);
        nrst = 1'b1;
        rd(CEPIR_OFS_IN_CONFIG, 8'h00, 1'b1);
        rd(CEPIR_OFS_IN_BYTE_COUNT, 8'h80, 1'b1);
        in_tx(CEPIR_HS_NAK, 1'b0);
        $display("reset test done");
        for (int c = 0; c < 4; c++) begin
            wr(CEPIR_OFS_IN_CONFIG, 8'(c));
            `CHK(buffer_bytes, 7'h08 << c)
            `CHK(in_buf_start, 16'hE000 + (16'h0008 << c))
            `CHK(out_buf_start, 16'hE000)
        end
        $display("size test done");
        wr(CEPIR_OFS_IN_CONFIG, 8'h44);
        wr(CEPIR_OFS_IN_BYTE_COUNT, 8'h45);
        rd(CEPIR_OFS_IN_BYTE_COUNT, 8'h40, 1'b1);
        wr(CEPIR_OFS_IN_BYTE_COUNT, 8'h05);
        `CHK(tx_count, 7'h05)
        in_tx(CEPIR_HS_DATA, 1'b1);
        `CHK(data_toggle_bit, 1'b1)
        rd(CEPIR_OFS_IN_BYTE_COUNT, 8'h85, 1'b1);
        in_tx(CEPIR_HS_NAK, 1'b1);
        $display("transfer test done");
        wr(CEPIR_OFS_IN_CONFIG, 8'hB8);
        `CHK(buf_mgr_enable, 1'b1)
        in_tx(CEPIR_HS_STALL, 1'b0);
        @(negedge clock);
        do_setup = 1'b1;
        @(negedge clock);
        do_setup = 1'b0;
        rd(CEPIR_OFS_IN_CONFIG, 8'h80, 1'b1);
        `CHK(data_toggle_bit, 1'b0)
        rd(16'hF002, 8'h00, 1'b0);
        wr(CEPIR_OFS_IN_CONFIG, 8'h04);
        @(negedge clock);
        do_setup = 1'b1;
        @(negedge clock);
        do_setup = 1'b0;
        `CHK(irq, 1'b1)
        $display("stall test done");
        complete_run();
    end
endmodule
